// file: include/fpg_defines.svh
// Constants of the flash and EEPROM write and read-out guard
`ifndef FPG_DEFINES_SVH
`define FPG_DEFINES_SVH
`define FPG_REG_AW 3
`define FPG_REG_KEY 3'h0
`define FPG_REG_CTRL 3'h1
`define FPG_REG_STAT 3'h2
`define FPG_REG_BOOT 3'h3
`define FPG_REG_RLK 3'h4
`define FPG_KEY1 8'hA5
`define FPG_KEY2 8'h5A
`define FPG_CTRL_RELOCK 0
`define FPG_ST_UNL 0
`define FPG_ST_RLK 1
`define FPG_ST_ICP 2
`define FPG_ST_DBG 3
`define FPG_PAGE_BYTES 512
`define FPG_PAGE_LSB 9
`define FPG_PROG_AW 15
`define FPG_PAGE_W 7
`define FPG_PAGES_MAX 7'h40
`define FPG_OPT_BOOT 15'h0001
`define FPG_OPT_RLK 15'h0000
`define FPG_RLK_OFF 8'h00
`define FPG_BOOT_RST 7'h00
`endif

// file: include/fpg_pkg.sv
// Types of the flash and EEPROM write and read-out guard
`include "fpg_defines.svh"
package fpg_pkg;
  typedef enum logic [1:0] {FPG_SP_PROG, FPG_SP_EE, FPG_SP_OPT, FPG_SP_NONE} fpg_space_t;
  typedef enum logic [1:0] {FPG_K_LOCKED, FPG_K_ONE, FPG_K_OPEN} fpg_key_t;
  typedef struct packed {
    logic valid;
    logic wr;
    logic tool;
    fpg_space_t space;
    logic [`FPG_PROG_AW-1:0] addr;
    logic [7:0] data;
  } fpg_req_t;
  typedef struct packed {
    logic wr_ok;
    logic rd_ok;
    logic refused;
  } fpg_ans_t;
  typedef struct packed {
    logic [1:0] mode_meta;
    logic [1:0] mode;
    fpg_key_t key;
    logic unl;
    logic [`FPG_PAGE_W-1:0] boot_pages;
    logic [7:0] rlk_byte;
    fpg_ans_t ans;
    logic erase;
    logic [7:0] rdata;
  } fpg_state_t;
endpackage

// file: rtl/fpg_guard.sv
// Write lock, boot-code region and read-out lock guard for Flash, EEPROM and options
//
// Summary of operation
// - CPU writes to program Flash, EEPROM and options stay locked until explicitly unlocked.
// - Writing both unlock keys in order opens CPU writes to those memories.
// - Boot-code region size is an option value counted in 512-byte pages.
// - Program memory splits into boot-code region up to 32 Kbyte and main rest.
// - Boot-code region stays write-protected for CPU even after unlocking.
// - With read-out lock on, tool access to Flash and EEPROM is refused in ICP or debug mode.
// - Clearing an active read-out lock to 00 triggers a global memory erase.
// - EEPROM writes proceed while code keeps executing from program Flash.
`timescale 1ns/1ps
`default_nettype none
`include "fpg_defines.svh"
module fpg_guard (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [`FPG_REG_AW-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic icp_mode_pin_i,
  input wire logic debug_mode_pin_i,
  input wire logic fetch_active_i,
  input wire fpg_pkg::fpg_req_t req_i,
  output fpg_pkg::fpg_ans_t ans_o,
  output logic erase_o,
  output logic write_unlocked_o
);
  import fpg_pkg::*;

  fpg_state_t st;
  fpg_state_t next_st;

  // Address falls inside the boot-code region
  function automatic logic in_boot(input logic [`FPG_PROG_AW-1:0] addr,
                                   input logic [`FPG_PAGE_W-1:0] pages);
    logic [`FPG_PAGE_W-1:0] page;
    page = {1'b0, addr[`FPG_PROG_AW-1:`FPG_PAGE_LSB]};
    in_boot = page < pages;
  endfunction

  // Whether a request may proceed
  function automatic logic permit(input fpg_req_t r, input logic open,
                                  input logic rlk, input logic in_circuit_programming_mode,
                                  input logic dbg,
                                  input logic [`FPG_PAGE_W-1:0] pages);
    logic blocked;
    blocked = r.tool && rlk && (in_circuit_programming_mode || dbg) && (r.space != FPG_SP_OPT);
    permit = 1'b0;
    if (r.space == FPG_SP_NONE) begin
      permit = 1'b0;
    end else if (!r.wr) begin
      permit = !blocked;
    end else if (r.tool) begin
      permit = (in_circuit_programming_mode || dbg) && !blocked;
    end else if (r.space == FPG_SP_PROG) begin
      permit = open && !in_boot(r.addr, pages);
    end else if (r.space == FPG_SP_OPT) begin
      permit = open && (r.addr != `FPG_OPT_BOOT);
    end else begin
      permit = open;
    end
  endfunction

  logic ok;
  logic rlk_on;

  always_comb begin
    next_st = st;
    next_st.mode_meta = {icp_mode_pin_i, debug_mode_pin_i};
    next_st.mode = st.mode_meta;
    next_st.ans = '0;
    next_st.erase = 1'b0;
    next_st.rdata = 8'h00;
    rlk_on = st.rlk_byte != `FPG_RLK_OFF;
    ok = permit(req_i, st.unl, rlk_on, st.mode[1], st.mode[0], st.boot_pages);
    if (reg_wr_i) begin
      if (reg_addr_i == `FPG_REG_KEY) begin
        case (st.key)
          FPG_K_LOCKED: begin
            next_st.key = (reg_wdata_i == `FPG_KEY1) ? FPG_K_ONE : FPG_K_LOCKED;
          end
          FPG_K_ONE: begin
            next_st.key = (reg_wdata_i == `FPG_KEY2) ? FPG_K_OPEN : FPG_K_LOCKED;
          end
          default: begin
            next_st.key = st.key;
          end
        endcase
      end else if (reg_addr_i == `FPG_REG_CTRL) begin
        if (reg_wdata_i[`FPG_CTRL_RELOCK]) begin
          next_st.key = FPG_K_LOCKED;
        end
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `FPG_REG_STAT) begin
        next_st.rdata[`FPG_ST_UNL] = st.unl;
        next_st.rdata[`FPG_ST_RLK] = rlk_on;
        next_st.rdata[`FPG_ST_ICP] = st.mode[1];
        next_st.rdata[`FPG_ST_DBG] = st.mode[0];
      end else if (reg_addr_i == `FPG_REG_BOOT) begin
        next_st.rdata = {1'b0, st.boot_pages};
      end else if (reg_addr_i == `FPG_REG_RLK) begin
        next_st.rdata = st.rlk_byte;
      end
    end
    if (req_i.valid) begin
      next_st.ans.wr_ok = ok && req_i.wr;
      next_st.ans.rd_ok = ok && !req_i.wr;
      next_st.ans.refused = !ok;
      if (ok && req_i.wr && req_i.space == FPG_SP_OPT) begin
        if (req_i.addr == `FPG_OPT_BOOT) begin
          next_st.boot_pages = (req_i.data[`FPG_PAGE_W-1:0] > `FPG_PAGES_MAX) ?
                               `FPG_PAGES_MAX : req_i.data[`FPG_PAGE_W-1:0];
        end else if (req_i.addr == `FPG_OPT_RLK) begin
          if (rlk_on && req_i.data == `FPG_RLK_OFF) begin
            next_st.erase = 1'b1;
          end
          next_st.rlk_byte = req_i.data;
        end
      end
    end
    next_st.unl = next_st.key == FPG_K_OPEN;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
      st.key <= FPG_K_LOCKED;
      st.boot_pages <= `FPG_BOOT_RST;
      st.rlk_byte <= `FPG_RLK_OFF;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign ans_o = st.ans;
  assign erase_o = st.erase;
  assign write_unlocked_o = st.unl;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_locked_cpu_write: assert property (
    req_i.valid && req_i.wr && !req_i.tool && !st.unl && req_i.space != FPG_SP_NONE
    |=> ans_o.refused && !ans_o.wr_ok)
    else $error("locked CPU write was granted");

  a_key_opens_lock: assert property (
    $rose(write_unlocked_o) |->
    $past(reg_wr_i && reg_addr_i == `FPG_REG_KEY && reg_wdata_i == `FPG_KEY2)
    && $past(st.key == FPG_K_ONE))
    else $error("write lock opened without key sequence");

  a_boot_size_max: assert property (
    st.boot_pages <= `FPG_PAGES_MAX)
    else $error("boot region larger than program memory");

  a_boot_cpu_wr: assert property (
    req_i.valid && req_i.wr && !req_i.tool && req_i.space == FPG_SP_PROG
    && in_boot(req_i.addr, st.boot_pages)
    |=> ans_o.refused)
    else $error("CPU write into boot region granted");

  a_rlk_tool_block: assert property (
    req_i.valid && req_i.tool && st.rlk_byte != `FPG_RLK_OFF
    && (st.mode != 2'b00) && req_i.space inside {FPG_SP_PROG, FPG_SP_EE}
    |=> ans_o.refused && !ans_o.rd_ok)
    else $error("tool access passed read-out lock");

  a_rlk_erase: assert property (
    erase_o |-> $past(st.rlk_byte != `FPG_RLK_OFF) && st.rlk_byte == `FPG_RLK_OFF
    && $past(req_i.valid && req_i.space == FPG_SP_OPT && req_i.addr == `FPG_OPT_RLK))
    else $error("erase without read-out lock change");

  a_rlk_toggle: assert property (
    st.rlk_byte != `FPG_RLK_OFF ##1 st.rlk_byte == `FPG_RLK_OFF |-> erase_o)
    else $error("read-out lock cleared without erase");

  a_ee_during_fetch: assert property (
    req_i.valid && req_i.wr && !req_i.tool && req_i.space == FPG_SP_EE
    && st.unl && fetch_active_i |=> ans_o.wr_ok)
    else $error("EEPROM write stalled by fetch");

  a_refused_keeps: assert property (
    ans_o.refused |-> $stable(st.boot_pages) && $stable(st.rlk_byte) && !erase_o)
    else $error("refused write changed stored options");

  a_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read answer");

  a_ans_onehot: assert property (
    req_i.valid
    |=> $onehot({ans_o.wr_ok, ans_o.rd_ok, ans_o.refused}))
    else $error("request answer not exactly one bit");

  a_ans_idle: assert property (
    !req_i.valid
    |=> ans_o == '0)
    else $error("answer without request");

  a_none_refused: assert property (
    req_i.valid && req_i.space == FPG_SP_NONE
    |=> ans_o.refused)
    else $error("request to no space granted");

  a_cpu_read_ok: assert property (
    req_i.valid && !req_i.wr && !req_i.tool && req_i.space != FPG_SP_NONE
    |=> ans_o.rd_ok)
    else $error("CPU read refused");

  a_tool_nomode: assert property (
    req_i.valid && req_i.wr && req_i.tool && st.mode == 2'b00
    |=> ans_o.refused)
    else $error("tool write granted outside programming mode");

  a_cpu_opt_boot: assert property (
    req_i.valid && req_i.wr && !req_i.tool && req_i.space == FPG_SP_OPT
    && req_i.addr == `FPG_OPT_BOOT |=> ans_o.refused && $stable(st.boot_pages))
    else $error("CPU changed boot region size");

  a_boot_hold: assert property (
    !(req_i.valid && req_i.wr && req_i.space == FPG_SP_OPT)
    |=> $stable(st.boot_pages))
    else $error("boot region size changed without option write");

  a_rlk_hold: assert property (
    !(req_i.valid && req_i.wr && req_i.space == FPG_SP_OPT)
    |=> $stable(st.rlk_byte))
    else $error("read-out lock changed without option write");

  a_erase_pulse: assert property (
    erase_o
    |=> !erase_o)
    else $error("erase pulse longer than one cycle");

  a_key_relock: assert property (
    reg_wr_i && reg_addr_i == `FPG_REG_CTRL && reg_wdata_i[`FPG_CTRL_RELOCK]
    |=> !write_unlocked_o)
    else $error("relock did not close write lock");

  a_key_wrong: assert property (
    reg_wr_i && reg_addr_i == `FPG_REG_KEY && st.key == FPG_K_ONE
    && reg_wdata_i != `FPG_KEY2 |=> !write_unlocked_o)
    else $error("wrong second key opened write lock");

  a_unl_keeps: assert property (
    write_unlocked_o && !(reg_wr_i && reg_addr_i == `FPG_REG_CTRL)
    |=> write_unlocked_o)
    else $error("write lock closed without relock");

  a_unl_matches: assert property (
    write_unlocked_o == (st.key == FPG_K_OPEN))
    else $error("unlock flag differs from key state");

  a_open_ee_ok: assert property (
    req_i.valid && req_i.wr && !req_i.tool && req_i.space == FPG_SP_EE
    && st.unl |=> ans_o.wr_ok)
    else $error("unlocked EEPROM write refused");

  a_main_cpu_ok: assert property (
    req_i.valid && req_i.wr && !req_i.tool && req_i.space == FPG_SP_PROG
    && st.unl && !in_boot(req_i.addr, st.boot_pages) |=> ans_o.wr_ok)
    else $error("unlocked main area write refused");

  a_rlk_status: assert property (
    reg_rd_i && reg_addr_i == `FPG_REG_STAT
    |=> reg_rdata_o[`FPG_ST_RLK] == $past(st.rlk_byte != `FPG_RLK_OFF))
    else $error("status shows wrong read-out lock state");

  a_boot_readback: assert property (
    reg_rd_i && reg_addr_i == `FPG_REG_BOOT
    |=> reg_rdata_o == {1'b0, $past(st.boot_pages)})
    else $error("boot size read back wrong");

  a_tool_open_rd: assert property (
    req_i.valid && !req_i.wr && req_i.tool && st.rlk_byte == `FPG_RLK_OFF
    && req_i.space != FPG_SP_NONE |=> ans_o.rd_ok)
    else $error("tool read refused without read-out lock");

  a_opt_write_rlk: assert property (
    req_i.valid && req_i.wr && req_i.tool && req_i.space == FPG_SP_OPT
    && req_i.addr == `FPG_OPT_RLK && st.mode != 2'b00
    |=> st.rlk_byte == $past(req_i.data))
    else $error("read-out lock byte not stored");

  c_unlock: cover property ($rose(write_unlocked_o));
  c_rlk_block: cover property (ans_o.refused && st.rlk_byte != `FPG_RLK_OFF);
  c_erase: cover property (erase_o);
  c_boot_refused: cover property (ans_o.refused && write_unlocked_o && st.boot_pages != 7'h00);
  c_ee_write: cover property (ans_o.wr_ok && fetch_active_i);
endmodule
`default_nettype wire

// file: verification/fpg_far_model.sv
// Far-side model: CPU and external tool requests, mode pins
`timescale 1ns/1ps
`default_nettype none
`include "fpg_defines.svh"
module fpg_far_model (
  input wire logic clk_i,
  output fpg_pkg::fpg_req_t req_o,
  output logic icp_o,
  output logic dbg_o
);
  import fpg_pkg::*;
  initial begin
    req_o = '0;
    icp_o = 1'b0;
    dbg_o = 1'b0;
  end
  // Mode pins, then room for the sync stages
  task automatic mode(input logic in_circuit_programming_mode, input logic dbg);
    @(posedge clk_i);
    icp_o <= in_circuit_programming_mode;
    dbg_o <= dbg;
    repeat (3) @(posedge clk_i);
  endtask
  // One byte request, one cycle
  task automatic access(input logic [1:0] wt, input fpg_space_t sp,
      input logic [`FPG_PROG_AW-1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{1'b1, wt[1], wt[0], sp, a, d};
    @(posedge clk_i);
    req_o <= '0;
  endtask
endmodule
`default_nettype wire

// file: verification/test_flash_eeprom_write_readout_guard.sv
// Testbench of the write and read-out guard
`timescale 1ns/1ps
`default_nettype none
`include "fpg_defines.svh"
module test_flash_eeprom_write_readout_guard;
  import fpg_pkg::*;
  localparam fpg_ans_t OK = 3'h4;
  localparam fpg_ans_t RD = 3'h2;
  localparam fpg_ans_t NO = 3'h1;
  logic clk_i, reset_i, reg_wr, reg_rd, fetch, erase, unl, in_circuit_programming_mode, dbg;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  fpg_req_t req;
  fpg_ans_t ans;
  int errors, n_compared, cycles;
  fpg_guard uut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .icp_mode_pin_i(in_circuit_programming_mode), .debug_mode_pin_i(dbg),
    .fetch_active_i(fetch), .req_i(req), .ans_o(ans), .erase_o(erase),
    .write_unlocked_o(unl));
  fpg_far_model far (.clk_i(clk_i), .req_o(req), .icp_o(in_circuit_programming_mode), .dbg_o(dbg));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic summarize();
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ans(input fpg_ans_t got, input fpg_ans_t exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_i);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1 chk8(reg_rdata, exp);
  endtask
  task automatic mem(input logic [1:0] wt, input fpg_space_t sp,
      input logic [14:0] a, input logic [7:0] d, input fpg_ans_t exp);
    far.access(wt, sp, a, d);
    #1 chk_ans(ans, exp);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    reset_i = 1'b1;
    {reg_wr, reg_rd, fetch, reg_addr, reg_wdata} = '0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`FPG_REG_STAT, 8'h00);
    mem(2'h2, FPG_SP_EE, 15'h0000, 8'h11, NO);
    wr(`FPG_REG_KEY, `FPG_KEY1);
    wr(`FPG_REG_KEY, 8'h00);
    wr(`FPG_REG_KEY, `FPG_KEY2);
    chk8({7'h00, unl}, 8'h00);
    wr(`FPG_REG_KEY, `FPG_KEY1);
    wr(`FPG_REG_KEY, `FPG_KEY2);
    rd(`FPG_REG_STAT, 8'h01);
    fetch <= 1'b1;
    mem(2'h2, FPG_SP_EE, 15'h0003, 8'h22, OK);
    far.mode(1'b1, 1'b0);
    mem(2'h3, FPG_SP_OPT, 15'h0001, 8'h02, OK);
    rd(`FPG_REG_BOOT, 8'h02);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    mem(2'h2, FPG_SP_PROG, 15'h03FF, 8'h33, NO);
    mem(2'h2, FPG_SP_PROG, 15'h0400, 8'h33, OK);
    mem(2'h2, FPG_SP_OPT, 15'h0001, 8'h01, NO);
    rd(`FPG_REG_BOOT, 8'h02);
    mem(2'h3, FPG_SP_OPT, 15'h0001, 8'h7F, OK);
    rd(`FPG_REG_BOOT, 8'h40);
    mem(2'h2, FPG_SP_PROG, 15'h7FFF, 8'h44, NO);
    mem(2'h0, FPG_SP_PROG, 15'h7FFF, 8'h00, RD);
    wr(`FPG_REG_CTRL, 8'h01);
    mem(2'h2, FPG_SP_EE, 15'h0000, 8'h55, NO);
    mem(2'h3, FPG_SP_OPT, 15'h0000, 8'h5A, OK);
    rd(`FPG_REG_STAT, 8'h06);
    rd(`FPG_REG_RLK, 8'h5A);
    mem(2'h1, FPG_SP_EE, 15'h0000, 8'h00, NO);
    mem(2'h3, FPG_SP_PROG, 15'h7FFF, 8'h66, NO);
    far.mode(1'b0, 1'b1);
    mem(2'h1, FPG_SP_PROG, 15'h0000, 8'h00, NO);
    mem(2'h3, FPG_SP_OPT, 15'h0000, 8'h33, OK);
    chk8({7'h00, erase}, 8'h00);
    mem(2'h3, FPG_SP_OPT, 15'h0000, 8'h00, OK);
    chk8({7'h00, erase}, 8'h01);
    rd(`FPG_REG_STAT, 8'h08);
    rd(`FPG_REG_RLK, 8'h00);
    mem(2'h1, FPG_SP_EE, 15'h0000, 8'h00, RD);
    far.mode(1'b0, 1'b0);
    mem(2'h3, FPG_SP_EE, 15'h0000, 8'h77, NO);
    summarize();
  end
endmodule
`default_nettype wire
